// ==== core/adcsr_edge_sync.sv ====
// Two-stage synchroniser with rising-edge detect for a pin input
`timescale 1ns/1ps
module adcsr_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      rise
);
  import adcsr_pkg::*;

  adcsr_sync_state_t s_ff;
  adcsr_sync_state_t nxt_s;

  // ---------------------------------------------------------------
  // First stage feeds only the second; edge uses stages two and three
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s    = s_ff;
    nxt_s.s1 = pin_in;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rise = s_ff.s2 & ~s_ff.s3;
endmodule

// ==== core/adcsr_regs.sv ====
// Converter control, status, result and coefficient registers on APB
`timescale 1ns/1ps
`include "adcsr_defs.svh"
module adcsr_regs (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output adcsr_pkg::adcsr_core_cmd_t      core_cmd,
  input  wire adcsr_pkg::adcsr_core_res_t core_res,
  input  wire logic                       timer_zero_overflow_trigger,
  input  wire logic                       timer_one_overflow_trigger,
  input  wire logic                       port0_pin3_trigger,
  output logic                            irq,
  output logic                            dma_req,
  input  wire logic                       dma_ack
);
  import adcsr_pkg::*;

  adcsr_state_t s_ff;
  adcsr_state_t nxt_s;
  logic         pin_rise;
  logic         setup_ph;
  logic         access_ph;
  adcsr_sel_t   sel;
  logic         wr_acc;
  logic         rd_acc;
  logic         sw_start_wr;
  logic         trig;
  logic         start_ok;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic adcsr_sel_t decode(input logic [31:0] a);
    adcsr_sel_t r;
    r = ADCSR_SEL_NONE;
    case (a)
      `ADCSR_ADDR_CTRL:   r = ADCSR_SEL_CTRL;
      `ADCSR_ADDR_STATUS: r = ADCSR_SEL_STATUS;
      `ADCSR_ADDR_RESULT: r = ADCSR_SEL_RESULT;
      `ADCSR_ADDR_GAIN:   r = ADCSR_SEL_GAIN;
      `ADCSR_ADDR_OFFSET: r = ADCSR_SEL_OFFSET;
      default:            r = ADCSR_SEL_NONE;
    endcase
    return r;
  endfunction

  // Byte-lane merge for the sixteen-bit registers
  function automatic logic [`ADCSR_COEF_W-1:0] merge16(
    input logic [`ADCSR_COEF_W-1:0] old,
    input logic [31:0]              wd,
    input logic [3:0]               st
  );
    logic [`ADCSR_COEF_W-1:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Pin trigger synchroniser
  // ---------------------------------------------------------------
  adcsr_edge_sync u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (port0_pin3_trigger),
    .rise    (pin_rise)
  );

  // ---------------------------------------------------------------
  // Bus phase and transfer qualifiers
  // ---------------------------------------------------------------
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign sel       = decode(paddr);
  assign wr_acc    = access_ph & pwrite;
  assign rd_acc    = access_ph & ~pwrite;

  // Start write counts only when the written mode is software trigger
  assign sw_start_wr = wr_acc && (sel == ADCSR_SEL_CTRL) && pstrb[0]
                       && pwdata[`ADCSR_START_BIT]
                       && (pwdata[`ADCSR_MODE_HI:`ADCSR_MODE_LO] == `ADCSR_MODE_SOFT);

  // ---------------------------------------------------------------
  // Trigger source selection
  // ---------------------------------------------------------------
  always_comb begin
    case (s_ff.ctrl.trigger_select)
      `ADCSR_MODE_SOFT: trig = sw_start_wr;
      `ADCSR_MODE_CONTINUOUS_CONVERT: trig = 1'b1;
      `ADCSR_MODE_T0:   trig = timer_zero_overflow_trigger;
      `ADCSR_MODE_T1:   trig = timer_one_overflow_trigger;
      `ADCSR_MODE_PIN:  trig = pin_rise;
      default:          trig = 1'b0;
    endcase
  end

  // Converter must be powered and idle to accept a new start
  assign start_ok = trig & ~s_ff.ctrl.converter_disable & ~s_ff.busy;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s             = s_ff;
    nxt_s.start_pulse = 1'b0;
    nxt_s.irq_pulse   = 1'b0;

    // Read data and error are captured in the setup phase
    if (setup_ph) begin
      nxt_s.slverr = (sel == ADCSR_SEL_NONE);
      case (sel)
        ADCSR_SEL_CTRL:   nxt_s.prdata = {24'h000000, s_ff.ctrl};
        ADCSR_SEL_STATUS: nxt_s.prdata = {31'h00000000, s_ff.ready};
        ADCSR_SEL_RESULT: nxt_s.prdata = {16'h0000, 2'h0, s_ff.result, 2'h0};
        ADCSR_SEL_GAIN:   nxt_s.prdata = {16'h0000, s_ff.gain};
        ADCSR_SEL_OFFSET: nxt_s.prdata = {16'h0000, s_ff.offset};
        default:          nxt_s.prdata = 32'h00000000;
      endcase
    end

    // Register writes; start bit keeps the written value
    if (wr_acc) begin
      case (sel)
        ADCSR_SEL_CTRL: begin
          if (pstrb[0]) begin
            nxt_s.ctrl = adcsr_ctrl_t'(pwdata[`ADCSR_CTRL_W-1:0]);
          end
        end
        ADCSR_SEL_GAIN:   nxt_s.gain   = merge16(s_ff.gain, pwdata, pstrb);
        ADCSR_SEL_OFFSET: nxt_s.offset = merge16(s_ff.offset, pwdata, pstrb);
        default: begin
        end
      endcase
    end

    // Reading the result clears ready
    if (rd_acc && (sel == ADCSR_SEL_RESULT)) begin
      nxt_s.ready = 1'b0;
    end

    // Power-down clears ready and abandons any conversion in flight
    if (nxt_s.ctrl.converter_disable) begin
      nxt_s.ready = 1'b0;
      nxt_s.busy  = 1'b0;
    end

    if (dma_ack) begin
      nxt_s.dma_req = 1'b0;
    end

    // New result; sets win over same-cycle clears
    if (core_res.done && !s_ff.ctrl.converter_disable) begin
      nxt_s.result    = core_res.data;
      nxt_s.ready     = 1'b1;
      nxt_s.busy      = 1'b0;
      nxt_s.irq_pulse = s_ff.ctrl.interrupt_enable_bit;
      if (s_ff.ctrl.dma_enable) begin
        nxt_s.dma_req = 1'b1;
      end
    end

    if (start_ok && !core_res.done) begin
      nxt_s.busy        = 1'b1;
      nxt_s.start_pulse = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff             <= '0;
      s_ff.ctrl        <= adcsr_ctrl_t'(`ADCSR_CTRL_RST);
      s_ff.ready       <= `ADCSR_STATUS_RST;
      s_ff.result      <= `ADCSR_RESULT_RST;
      s_ff.gain        <= `ADCSR_COEF_RST;
      s_ff.offset      <= `ADCSR_COEF_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata                        = s_ff.prdata;
  assign pready                        = access_ph;
  assign pslverr                       = access_ph & s_ff.slverr;
  // One driver for the whole command struct
  assign core_cmd = '{start:                s_ff.start_pulse,
                      power_down:           s_ff.ctrl.converter_disable,
                      reference_buffer_off: s_ff.ctrl.reference_buffer_off};
  assign irq                           = s_ff.irq_pulse;
  assign dma_req                       = s_ff.dma_req;
endmodule

// ==== pkg/adcsr_defs.svh ====
// Constants for the converter control and status register block
// Functional notes
// - Control bit 7 high turns reference buffer off
// - Control bit 6 gates DMA requests, resets 0
// - Control bit 5 enables interrupt on results
// - Control bit 4 high disables the converter
// - Bits 3:1 select the conversion trigger source
// - Start bit starts only in software mode
// - Start bit never self-clears after conversion
// - Status bit 0 ready, bits 7:1 zero
// - Reading result clears the ready flag
// - Result holds 12 bits at 13:2, resets zero
// - Control register eight bits, reset 0x90
// - Status register eight bits, reset zero
// - Gain register sixteen bits read-write, reset zero
// - Offset register sixteen bits read-write, reset zero
// - Ready stays set until read, power-down, reset
// - Every new result pulses interrupt when enabled
// - Coefficients are stored only, never applied
`ifndef ADCSR_DEFS_SVH
`define ADCSR_DEFS_SVH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define ADCSR_ADDR_CTRL    32'h4005_0004
`define ADCSR_ADDR_STATUS  32'h4005_0008
`define ADCSR_ADDR_RESULT  32'h4005_000c
`define ADCSR_ADDR_GAIN    32'h4005_0010
`define ADCSR_ADDR_OFFSET  32'h4005_0014

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ADCSR_CTRL_RST     8'h90
`define ADCSR_STATUS_RST   1'h0
`define ADCSR_RESULT_RST   12'h000
`define ADCSR_COEF_RST     16'h0000

// ---------------------------------------------------------------
// Field layout
// ---------------------------------------------------------------
`define ADCSR_CTRL_W       8
`define ADCSR_COEF_W       16
`define ADCSR_RES_W        12
`define ADCSR_RES_LSB      2
`define ADCSR_START_BIT    0
`define ADCSR_MODE_HI      3
`define ADCSR_MODE_LO      1

// ---------------------------------------------------------------
// Trigger codes
// ---------------------------------------------------------------
`define ADCSR_MODE_SOFT    3'h0
`define ADCSR_MODE_CONTINUOUS_CONVERT    3'h1
`define ADCSR_MODE_T0      3'h3
`define ADCSR_MODE_T1      3'h4
`define ADCSR_MODE_PIN     3'h5

// ---------------------------------------------------------------
// Timing for software: reference buffer settling
// ---------------------------------------------------------------
`define ADCSR_CLK_HZ          10000000
`define ADCSR_REFERENCE_BUFFER_OFF_SETTLE_US 5000
`define ADCSR_REFERENCE_BUFFER_OFF_SETTLE_CYC ((`ADCSR_REFERENCE_BUFFER_OFF_SETTLE_US * (`ADCSR_CLK_HZ / 1000000)))

`endif

// ==== pkg/adcsr_pkg.sv ====
// Types shared by the converter control and status block
package adcsr_pkg;
  `include "adcsr_defs.svh"

  // ---------------------------------------------------------------
  // Register selection
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCSR_SEL_NONE,
    ADCSR_SEL_CTRL,
    ADCSR_SEL_STATUS,
    ADCSR_SEL_RESULT,
    ADCSR_SEL_GAIN,
    ADCSR_SEL_OFFSET
  } adcsr_sel_t;

  // ---------------------------------------------------------------
  // Control register fields, msb first
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       reference_buffer_off;
    logic       dma_enable;
    logic       interrupt_enable_bit;
    logic       converter_disable;
    logic [2:0] trigger_select;
    logic       sw_start;
  } adcsr_ctrl_t;

  // ---------------------------------------------------------------
  // Converter core carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       start;
    logic       power_down;
    logic       reference_buffer_off;
  } adcsr_core_cmd_t;

  typedef struct packed {
    logic                     done;
    logic [`ADCSR_RES_W-1:0]  data;
  } adcsr_core_res_t;

  // ---------------------------------------------------------------
  // Module state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } adcsr_sync_state_t;

  typedef struct packed {
    adcsr_ctrl_t              ctrl;
    logic                     ready;
    logic [`ADCSR_RES_W-1:0]  result;
    logic [`ADCSR_COEF_W-1:0] gain;
    logic [`ADCSR_COEF_W-1:0] offset;
    logic                     busy;
    logic                     start_pulse;
    logic                     irq_pulse;
    logic                     dma_req;
    logic [31:0]              prdata;
    logic                     slverr;
  } adcsr_state_t;
endpackage

// ==== test/adcsr_assertions.sv ====
// Port checker for the converter register block
`timescale 1ns/1ps
`include "adcsr_defs.svh"
module adcsr_assertions (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire adcsr_pkg::adcsr_core_cmd_t core_cmd,
  input wire adcsr_pkg::adcsr_core_res_t core_res,
  input wire logic                       irq,
  input wire logic                       dma_req
);
  import adcsr_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_ctrl;
  assign acc = psel && penable;
  assign wr_ctrl = acc && pwrite && pstrb[0] && paddr == `ADCSR_ADDR_CTRL;
  property p_reference_buffer_off;
    wr_ctrl |=> core_cmd.reference_buffer_off == $past(pwdata[7]);
  endproperty
  a_reference_buffer_off: assert property (p_reference_buffer_off) else $error("buffer level wrong");
  property p_pwr;
    wr_ctrl |=> core_cmd.power_down == $past(pwdata[4]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power level wrong");
  property p_irq;
    irq |-> $past(core_res.done) && !$past(core_cmd.power_down);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without result");
  property p_dma;
    $rose(dma_req) |-> $past(core_res.done);
  endproperty
  a_dma: assert property (p_dma) else $error("dma without result");
  property p_start_en;
    core_cmd.start |-> !$past(core_cmd.power_down);
  endproperty
  a_start_en: assert property (p_start_en) else $error("start while off");
  property p_start_pulse;
    core_cmd.start |=> !core_cmd.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_res_fmt;
    acc && !pwrite && paddr == `ADCSR_ADDR_RESULT |-> prdata[31:14] == 0 && prdata[1:0] == 0;
  endproperty
  a_res_fmt: assert property (p_res_fmt) else $error("result pad bits");
  property p_sta_fmt;
    acc && !pwrite && paddr == `ADCSR_ADDR_STATUS |-> prdata[31:1] == 0;
  endproperty
  a_sta_fmt: assert property (p_sta_fmt) else $error("status pad bits");
endmodule
bind adcsr_regs adcsr_assertions u_adcsr_assertions (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .core_cmd, .core_res, .irq, .dma_req);

// ==== test/adcsr_core_model.sv ====
// Behavioural converter core answering start pulses with one sample
`timescale 1ns/1ps
module adcsr_core_model (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire adcsr_pkg::adcsr_core_cmd_t cmd,
  input  wire logic [3:0]                 lat,
  input  wire logic [11:0]                sample,
  output adcsr_pkg::adcsr_core_res_t      res
);
  import adcsr_pkg::*;
  logic        busy_ff;
  logic [3:0]  cnt_ff;
  logic [11:0] last_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      last_ff <= 12'h000;
      res <= '0;
    end else begin
      res.done <= 1'b0;
      // Idle data shows the inverse of the last sample
      res.data <= ~last_ff;
      if (cmd.power_down) begin
        busy_ff <= 1'b0;
      end else if (cmd.start) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat;
      end else if (busy_ff && cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end else if (busy_ff) begin
        busy_ff <= 1'b0;
        res.done <= 1'b1;
        res.data <= sample;
        last_ff <= sample;
      end
    end
  end
endmodule

// ==== test/tb_adc_control_status_regs.sv ====
// Self-checking bench for the converter register block
`timescale 1ns/1ps
`include "adcsr_defs.svh"
module tb_adc_control_status_regs;
  import adcsr_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic t0 = 0, t1 = 0, pin = 0, dma_ack = 0, irq, dma_req, rerr;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rdata;
  logic [3:0] pstrb = 0, lat = 0;
  logic [11:0] sample = 0;
  adcsr_core_cmd_t core_cmd;
  adcsr_core_res_t core_res;
  int n_fail = 0, cmp_count = 0, irq_n = 0, st_n = 0, base, ib;
  int modes[6] = '{2, 3, 4, 5, 6, 7};
  adcsr_regs u_adcsr_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .core_cmd, .core_res,
    .timer_zero_overflow_trigger(t0), .timer_one_overflow_trigger(t1),
    .port0_pin3_trigger(pin), .irq, .dma_req, .dma_ack);
  adcsr_core_model u_adcsr_core_model (.pclk, .presetn, .cmd(core_cmd), .lat, .sample,
    .res(core_res));
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    irq_n <= irq_n + (irq === 1'b1);
    st_n <= st_n + (core_cmd.start === 1'b1);
  end
  // ----
  // Tasks
  // ----
  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task automatic wait_irq(input int n);
    for (int i = 0; i < 300 && irq_n < n; i++) @(posedge pclk);
  endtask
  initial begin
    repeat (80000) @(posedge pclk);
    n_fail++;
    give_verdict;
  end
  // ----
  // Tests
  // ----
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ADCSR_ADDR_CTRL, 32'h90);
    chk(core_cmd, 32'h3);
    rd(`ADCSR_ADDR_STATUS, 32'h0);
    rd(`ADCSR_ADDR_RESULT, 32'h0);
    rd(`ADCSR_ADDR_GAIN, 32'h0);
    rd(`ADCSR_ADDR_OFFSET, 32'h0);
    wr(`ADCSR_ADDR_GAIN, 32'hffffa5c3);
    rd(`ADCSR_ADDR_GAIN, 32'ha5c3);
    wr(`ADCSR_ADDR_OFFSET, 32'h00015a3c);
    rd(`ADCSR_ADDR_OFFSET, 32'h5a3c);
    wr(`ADCSR_ADDR_STATUS, 32'hff);
    rd(`ADCSR_ADDR_STATUS, 32'h0);
    wr(`ADCSR_ADDR_RESULT, 32'hffff);
    rd(`ADCSR_ADDR_RESULT, 32'h0);
    rd(32'h4005_0018, 32'h0);
    chk(rerr, 32'h1);
    wr(`ADCSR_ADDR_CTRL, 32'h91);
    cyc(20);
    chk(st_n, 32'h0);
    wr(`ADCSR_ADDR_CTRL, 32'h0);
    cyc(1);
    chk(core_cmd, 32'h0);
    cyc(`ADCSR_REFERENCE_BUFFER_OFF_SETTLE_CYC);
    lat <= 4'd9;
    sample <= 12'habc;
    wr(`ADCSR_ADDR_CTRL, 32'h61);
    wait_irq(1);
    chk(irq_n, 32'h1);
    chk(dma_req, 32'h1);
    rd(`ADCSR_ADDR_STATUS, 32'h1);
    rd(`ADCSR_ADDR_CTRL, 32'h61);
    chk(st_n, 32'h1);
    rd(`ADCSR_ADDR_RESULT, 32'h2af0);
    rd(`ADCSR_ADDR_STATUS, 32'h0);
    dma_ack <= 1'b1;
    cyc(1);
    dma_ack <= 1'b0;
    cyc(1);
    chk(dma_req, 32'h0);
    lat <= 4'd0;
    sample <= 12'h123;
    base = irq_n;
    wr(`ADCSR_ADDR_CTRL, 32'h62);
    wait_irq(base + 3);
    rd(`ADCSR_ADDR_STATUS, 32'h1);
    chk(irq_n >= base + 3, 32'h1);
    wr(`ADCSR_ADDR_CTRL, 32'h72);
    rd(`ADCSR_ADDR_STATUS, 32'h0);
    rd(`ADCSR_ADDR_RESULT, 32'h48c);
    dma_ack <= 1'b1;
    cyc(2);
    dma_ack <= 1'b0;
    ib = irq_n;
    foreach (modes[i]) begin
      base = st_n;
      wr(`ADCSR_ADDR_CTRL, 32'h81 | (modes[i] << 1));
      t0 <= 1'b1;
      cyc(1);
      t0 <= 1'b0;
      cyc(12);
      t1 <= 1'b1;
      cyc(1);
      t1 <= 1'b0;
      cyc(12);
      pin <= 1'b1;
      cyc(6);
      pin <= 1'b0;
      cyc(12);
      chk(st_n - base, modes[i] inside {3, 4, 5});
    end
    chk(irq_n - ib, 32'h0);
    chk(dma_req, 32'h0);
    give_verdict;
  end
endmodule
